// ==== design/flash_front_regs.svh ====
`ifndef FLASH_FRONT_REGS_SVH
`define FLASH_FRONT_REGS_SVH

// command codes on the serial link
`define OP_WRITE_ENABLE   8'h06
`define OP_WRITE_DISABLE  8'h04
`define OP_READ_STATUS    8'h05
`define OP_STATUS_WRITE   8'h01
`define OP_READ           8'h03
`define OP_FAST_READ      8'h0B
`define OP_DUAL_READ      8'h3B
`define OP_PAGE_PROGRAM   8'h02
`define OP_SECTOR_ERASE   8'h20
`define OP_BLOCK_ERASE_A  8'h52
`define OP_BLOCK_ERASE_B  8'hD8
`define OP_CHIP_ERASE_A   8'h60
`define OP_CHIP_ERASE_B   8'hC7
`define OP_POWER_DOWN     8'hB9
`define OP_RELEASE_PD     8'hAB

// array geometry
`define ARRAY_BYTES       65536
`define PAGE_BYTES        256
`define SECTOR_LAST       12'hFFF
`define SECTOR_FIRST      12'h000
`define CHIP_FIRST        16'h0000
`define CHIP_LAST         16'hFFFF
`define ERASED_BYTE       8'hFF
`define ADDR_BYTES        2'h3

// register offsets on the bus
`define OFS_STATUS        12'h000
`define OFS_SIGNATURE     12'h004
`define SIGNATURE_RESET   8'h5A
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// ==== design/flash_front_pkg.sv ====
package flash_front_pkg;

  // status byte as seen over the serial link
  typedef struct packed {
    logic       status_write_disable;
    logic [2:0] reserved;
    logic       protect_bit1;
    logic       protect_bit0;
    logic       write_enable_latch;
    logic       write_in_progress;
  } status_t;

  // serial pins after the synchroniser
  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic hold_n;
    logic wp_n;
    logic io0;
    logic io1;
  } pins_t;

  typedef enum logic [2:0] {PH_OPCODE, PH_ADDR, PH_DUMMY, PH_DATA_IN, PH_DATA_OUT, PH_IGNORE} phase_t;
  typedef enum logic [1:0] {ENG_IDLE, ENG_WRITE, ENG_VERIFY} eng_t;

endpackage

// ==== design/flash_front.sv ====
// Our own choices: the AXI4-Lite interface to the registers and the address map.
`include "flash_front_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module flash_front
  import flash_front_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write channels
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read channels
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // serial flash pins
  input  wire logic        cs_n,
  input  wire logic        sclk,
  input  wire logic        hold_n,
  input  wire logic        wp_n,
  input  wire logic        data_in_io0_i,
  output logic             data_in_io0_o,
  output logic             data_in_io0_oe,
  input  wire logic        data_out_io1_i,
  output logic             data_out_io1_o,
  output logic             data_out_io1_oe
);

  // pin synchroniser: stage one feeds only stage two
  pins_t       meta_q;                     // first stage
  pins_t       pin_q;                      // second stage, safe to read
  pins_t       last_q;                     // previous value for edges
  // edges of the sampled link
  logic        sclk_rise, sclk_fall, cs_rise, selected;
  // hold and interface state
  logic        hold_q;                     // serial traffic paused
  phase_t      phase_q;                    // command phase
  logic [2:0]  bit_cnt_q;                  // bits of current byte
  logic [7:0]  in_sr_q;                    // incoming shift register
  logic [7:0]  cmd_q;                      // latched opcode
  logic [1:0]  addr_cnt_q;                 // address bytes taken
  logic [15:0] addr_q;                     // low 16 address bits
  logic [7:0]  out_byte_q;                 // byte being shifted out
  logic        dual_q;                     // two bits per clock
  logic        out_en_q;                   // output phase reached
  logic        io1_q, io0_q;               // driven data bits
  logic [7:0]  new_status_q;               // byte of a status write
  logic        got_status_q;               // status byte arrived
  logic [7:0]  pbuf [0:`PAGE_BYTES-1];     // page program buffer
  logic [`PAGE_BYTES-1:0] pvalid_q;        // buffered bytes present
  logic [7:0]  pp_idx_q;                   // next buffer slot
  // device state
  status_t     status_q;
  logic        deep_pd_q;                  // deep power-down
  logic        verify_fail_q;              // sticky verify mismatch
  eng_t        eng_q;
  logic        eng_prog_q;                 // program, else erase
  logic [15:0] eng_addr_q, eng_end_q;
  logic [7:0]  eng_exp_q;                  // expected byte for verify
  logic [7:0]  mem [0:`ARRAY_BYTES-1];     // the array
  logic [7:0]  sig_q;                      // signature, software set

  // synchronise every pin through two flops
  always_ff @(posedge aclk)
  begin
    meta_q <= pins_t'({cs_n, sclk, hold_n, wp_n, data_in_io0_i, data_out_io1_i});
    pin_q  <= meta_q;
    last_q <= pin_q;
  end

  // edges come from the second stage only; either idle level is fine
  assign selected  = ~pin_q.cs_n;
  assign sclk_rise = selected & pin_q.sclk & ~last_q.sclk & ~hold_q;
  assign sclk_fall = selected & ~pin_q.sclk & last_q.sclk & ~hold_q;
  assign cs_rise   = pin_q.cs_n & ~last_q.cs_n;

  // decode of the byte finishing on this rising edge
  logic [7:0] byte_in;
  logic       byte_done;
  logic       is_be, is_ce, is_known, allowed;
  assign byte_in   = {in_sr_q[6:0], pin_q.io0};
  assign byte_done = sclk_rise & (dual_q ? (bit_cnt_q[1:0] == 2'h3) : (bit_cnt_q == 3'h7));
  assign is_be     = (byte_in == `OP_BLOCK_ERASE_A) | (byte_in == `OP_BLOCK_ERASE_B);
  assign is_ce     = (byte_in == `OP_CHIP_ERASE_A) | (byte_in == `OP_CHIP_ERASE_B);
  assign is_known  = (byte_in == `OP_WRITE_ENABLE) | (byte_in == `OP_WRITE_DISABLE)
                   | (byte_in == `OP_READ_STATUS) | (byte_in == `OP_STATUS_WRITE)
                   | (byte_in == `OP_READ) | (byte_in == `OP_FAST_READ)
                   | (byte_in == `OP_DUAL_READ) | (byte_in == `OP_PAGE_PROGRAM)
                   | (byte_in == `OP_SECTOR_ERASE) | is_be | is_ce
                   | (byte_in == `OP_POWER_DOWN) | (byte_in == `OP_RELEASE_PD);
  // power-down lets only release through; while busy only status reads pass
  assign allowed   = is_known
                   & (~deep_pd_q | (byte_in == `OP_RELEASE_PD))
                   & (~status_q.write_in_progress | (byte_in == `OP_READ_STATUS));

  // hold follows the pause pin, but only while the serial clock is low
  always_ff @(posedge aclk)
  begin
    if (!aresetn || pin_q.cs_n)
      hold_q <= 1'b0;
    else if (!pin_q.sclk && !pin_q.hold_n)
      hold_q <= 1'b1;
    else if (!pin_q.sclk && pin_q.hold_n)
      hold_q <= 1'b0;
  end

  // serial command shifter; frozen whenever hold is active
  always_ff @(posedge aclk)
  begin
    if (!aresetn || pin_q.cs_n)
    begin
      // deselect, also during hold, returns the interface to idle
      phase_q   <= PH_OPCODE;
      bit_cnt_q <= 3'h0;
      dual_q    <= 1'b0;
      out_en_q  <= 1'b0;
      addr_cnt_q <= 2'h0;
      if (!aresetn)
      begin
        cmd_q        <= 8'h00;
        got_status_q <= 1'b0;
        pvalid_q     <= '0;
      end
    end
    else if (sclk_rise)
    begin
      // input bits are taken on the rising edge
      in_sr_q   <= byte_in;
      bit_cnt_q <= bit_cnt_q + 3'h1;
      if (byte_done)
      begin
        case (phase_q)
          PH_OPCODE:
          begin
            cmd_q        <= byte_in;
            got_status_q <= 1'b0;
            if (!allowed)
              phase_q <= PH_IGNORE;
            else if (byte_in == `OP_READ_STATUS)
            begin
              phase_q    <= PH_DATA_OUT;
              out_en_q   <= 1'b1;
              out_byte_q <= status_q;
            end
            else if (byte_in == `OP_STATUS_WRITE)
              phase_q <= PH_DATA_IN;
            else if ((byte_in == `OP_WRITE_ENABLE) || (byte_in == `OP_WRITE_DISABLE)
                     || (byte_in == `OP_POWER_DOWN) || is_ce)
              phase_q <= PH_DATA_IN;       // trailing bytes change nothing
            else
            begin
              phase_q  <= PH_ADDR;
              pvalid_q <= '0;
            end
          end
          PH_ADDR:
          begin
            addr_q     <= {addr_q[7:0], byte_in};
            addr_cnt_q <= addr_cnt_q + 2'h1;
            if (addr_cnt_q == `ADDR_BYTES - 2'h1)
            begin
              pp_idx_q <= byte_in;         // page offset wraps inside page
              if (cmd_q == `OP_FAST_READ)
                phase_q <= PH_DUMMY;
              else if ((cmd_q == `OP_READ) || (cmd_q == `OP_DUAL_READ) || (cmd_q == `OP_RELEASE_PD))
              begin
                phase_q    <= PH_DATA_OUT;
                out_en_q   <= 1'b1;
                dual_q     <= (cmd_q == `OP_DUAL_READ);
                out_byte_q <= (cmd_q == `OP_RELEASE_PD) ? sig_q : mem[{addr_q[7:0], byte_in}];
                addr_q     <= {addr_q[7:0], byte_in} + 16'h1;
              end
              else
                phase_q <= PH_DATA_IN;
            end
          end
          PH_DUMMY:
          begin
            phase_q    <= PH_DATA_OUT;
            out_en_q   <= 1'b1;
            out_byte_q <= mem[addr_q];
            addr_q     <= addr_q + 16'h1;
          end
          PH_DATA_IN:
          begin
            if (cmd_q == `OP_STATUS_WRITE && !got_status_q)
            begin
              new_status_q <= byte_in;
              got_status_q <= 1'b1;
            end
            else if (cmd_q == `OP_PAGE_PROGRAM)
            begin
              pbuf[pp_idx_q]     <= byte_in;
              pvalid_q[pp_idx_q] <= 1'b1;
              pp_idx_q           <= pp_idx_q + 8'h1;
            end
          end
          PH_DATA_OUT:
          begin
            // reads run on until deselect; status is refreshed every byte
            if (cmd_q == `OP_READ_STATUS)
              out_byte_q <= status_q;
            else if (cmd_q == `OP_RELEASE_PD)
              out_byte_q <= sig_q;
            else
            begin
              out_byte_q <= mem[addr_q];
              addr_q     <= addr_q + 16'h1;
            end
          end
          PH_IGNORE: phase_q <= PH_IGNORE;
          default:   phase_q <= PH_IGNORE;
        endcase
      end
    end
  end

  // output bits change on the falling edge
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      io1_q <= 1'b0;
      io0_q <= 1'b0;
    end
    else if (sclk_fall && out_en_q)
    begin
      io1_q <= dual_q ? out_byte_q[3'h7 - {bit_cnt_q[1:0], 1'b0}] : out_byte_q[3'h7 - bit_cnt_q];
      io0_q <= out_byte_q[3'h6 - {bit_cnt_q[1:0], 1'b0}];
    end
  end

  // pins float when deselected, held or ignoring a command
  assign data_out_io1_o  = io1_q;
  assign data_out_io1_oe = selected & out_en_q & ~hold_q;
  assign data_in_io0_o   = io0_q;
  assign data_in_io0_oe  = selected & out_en_q & dual_q & ~hold_q;

  // a finished command acts only if its length ends on a byte boundary
  logic exec, protected_all, may_change;
  assign exec          = cs_rise & ~hold_q & (bit_cnt_q == 3'h0) & (phase_q != PH_IGNORE);
  assign protected_all = status_q.protect_bit0 | status_q.protect_bit1;  // levels 1..3
  assign may_change    = status_q.write_enable_latch & ~protected_all;

  // engine write port into the array
  logic       eng_we;
  logic [7:0] eng_wdata;
  assign eng_we    = (eng_q == ENG_WRITE);
  assign eng_wdata = eng_prog_q ? (pvalid_q[eng_addr_q[7:0]] ? (mem[eng_addr_q] & pbuf[eng_addr_q[7:0]])
                                                              : mem[eng_addr_q])
                                : `ERASED_BYTE;

  // status, power state and the program/erase engine
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      status_q      <= '0;               // latch clear at power-up
      deep_pd_q     <= 1'b0;             // power-up lands in standby
      verify_fail_q <= 1'b0;
      eng_q         <= ENG_IDLE;
      eng_prog_q    <= 1'b0;
      eng_addr_q    <= 16'h0000;
      eng_end_q     <= 16'h0000;
      eng_exp_q     <= 8'h00;
    end
    else
    begin
      case (eng_q)
        ENG_WRITE:
        begin
          eng_exp_q <= eng_wdata;
          eng_q     <= ENG_VERIFY;
        end
        ENG_VERIFY:
        begin
          if (mem[eng_addr_q] != eng_exp_q)
            verify_fail_q <= 1'b1;
          if (eng_addr_q == eng_end_q)
          begin
            eng_q                       <= ENG_IDLE;
            status_q.write_in_progress  <= 1'b0;
            status_q.write_enable_latch <= 1'b0;
          end
          else
          begin
            eng_addr_q <= eng_addr_q + 16'h1;
            eng_q      <= ENG_WRITE;
          end
        end
        ENG_IDLE: eng_q <= ENG_IDLE;
        default:  eng_q <= ENG_IDLE;
      endcase
      // the engine keeps going through hold; it never looks at hold
      if (exec)
      begin
        case (cmd_q)
          `OP_WRITE_ENABLE:  status_q.write_enable_latch <= 1'b1;
          `OP_WRITE_DISABLE: status_q.write_enable_latch <= 1'b0;
          `OP_STATUS_WRITE:
            if (got_status_q && status_q.write_enable_latch)
            begin
              status_q.write_enable_latch <= 1'b0;
              if (pin_q.wp_n)
              begin
                status_q.protect_bit0         <= new_status_q[2];
                status_q.protect_bit1         <= new_status_q[3];
                status_q.status_write_disable <= new_status_q[7];
              end
            end
          `OP_PAGE_PROGRAM:
            if (may_change && (|pvalid_q))
            begin
              eng_q                      <= ENG_WRITE;
              eng_prog_q                 <= 1'b1;
              eng_addr_q                 <= {addr_q[15:8], 8'h00};
              eng_end_q                  <= {addr_q[15:8], 8'hFF};
              status_q.write_in_progress <= 1'b1;
            end
          `OP_SECTOR_ERASE:
            if (may_change)
            begin
              eng_q                      <= ENG_WRITE;
              eng_prog_q                 <= 1'b0;
              eng_addr_q                 <= {addr_q[15:12], `SECTOR_FIRST};
              eng_end_q                  <= {addr_q[15:12], `SECTOR_LAST};
              status_q.write_in_progress <= 1'b1;
            end
          `OP_BLOCK_ERASE_A, `OP_BLOCK_ERASE_B, `OP_CHIP_ERASE_A, `OP_CHIP_ERASE_B:
            if (may_change)
            begin
              eng_q                      <= ENG_WRITE;
              eng_prog_q                 <= 1'b0;
              eng_addr_q                 <= `CHIP_FIRST;
              eng_end_q                  <= `CHIP_LAST;
              status_q.write_in_progress <= 1'b1;
            end
          `OP_POWER_DOWN:    deep_pd_q <= 1'b1;
          `OP_RELEASE_PD:    deep_pd_q <= 1'b0;
          default:           deep_pd_q <= deep_pd_q;
        endcase
      end
    end
  end

  // array storage has no reset; contents survive until erased
  always_ff @(posedge aclk)
  begin
    if (eng_we)
      mem[eng_addr_q] <= eng_wdata;
  end

  // standby: deselected with nothing running
  logic standby;
  assign standby = pin_q.cs_n & ~status_q.write_in_progress;

  // axi4-lite slave: address and data accepted in either order
  logic        aw_got_q, w_got_q;
  logic [11:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        wr_go, rd_go;
  logic [31:0] rd_word;
  logic        rd_hit;
  assign s_axi_awready = ~aw_got_q & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_got_q & ~s_axi_bvalid;
  assign wr_go         = aw_got_q & w_got_q;
  assign s_axi_arready = ~s_axi_rvalid;
  assign rd_go         = s_axi_arvalid & s_axi_arready;
  assign rd_hit        = (s_axi_araddr == `OFS_STATUS) | (s_axi_araddr == `OFS_SIGNATURE);
  assign rd_word       = (s_axi_araddr == `OFS_STATUS)
                       ? {20'h00000, verify_fail_q, standby, deep_pd_q, hold_q, status_q}
                       : {24'h000000, sig_q};

  // write side: latch each channel, answer once both are in
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_q     <= 1'b0;
      w_got_q      <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
      sig_q        <= `SIGNATURE_RESET;  // arbitrary value
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_q  <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_q  <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_got_q     <= 1'b0;
        w_got_q      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= ((aw_addr_q == `OFS_STATUS) || (aw_addr_q == `OFS_SIGNATURE)) ? `RESP_OKAY
                                                                                       : `RESP_SLVERR;
        if ((aw_addr_q == `OFS_SIGNATURE) && w_strb_q[0])
          sig_q <= w_data_q[7:0];
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // read side: one cycle from address to data
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `RESP_OKAY;
    end
    else if (rd_go)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_hit ? rd_word : 32'h00000000;
      s_axi_rresp  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule // flash_front

`default_nettype wire

// ==== bench/flash_front_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module flash_front_monitor (
  // clock and reset
  input wire logic       aclk,
  input wire logic       aresetn,
  // bus handshakes
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  input wire logic [1:0] s_axi_rresp,
  // serial pins
  input wire logic       cs_n,
  input wire logic       sclk,
  input wire logic       hold_n,
  input wire logic       data_out_io1_o,
  input wire logic       data_out_io1_oe
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // eight cycles cover both synchronisers and the hold flop
  sequence s_desel;
    cs_n [*8];
  endsequence
  sequence s_held;
    (!hold_n && !sclk) [*8];
  endsequence
  property p_rst;
    disable iff (1'b0) !aresetn |=> !data_out_io1_oe && !s_axi_bvalid && !s_axi_rvalid;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs active after reset");
  property p_desel;
    s_desel |-> !data_out_io1_oe;
  endproperty
  a_desel: assert property (p_desel) else $error("output driven while deselected");
  property p_hold;
    s_held |-> !data_out_io1_oe;
  endproperty
  a_hold: assert property (p_hold) else $error("output driven while paused");
  // a new output bit only follows a falling clock
  property p_shift;
    data_out_io1_oe && $past(data_out_io1_oe) && $changed(data_out_io1_o) |-> !$past(sclk, 2);
  endproperty
  a_shift: assert property (p_shift) else $error("output bit moved off falling edge");
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped early");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rresp);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read answer dropped early");
  property p_ar;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_ar: assert property (p_ar) else $error("read answer late");
  property p_wblk;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_wblk: assert property (p_wblk) else $error("write taken while answer pending");
endmodule // flash_front_monitor
bind flash_front flash_front_monitor mon (.aclk, .aresetn, .s_axi_awready, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rresp,
  .cs_n, .sclk, .hold_n, .data_out_io1_o, .data_out_io1_oe);
`default_nettype wire

// ==== bench/spi_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  // pacing clock
  input  wire logic clk,
  // link pins, idle deselected with pause and protect released
  output var logic  cs_n = 1'b1,
  output var logic  sclk = 1'b0,
  output var logic  hold_n = 1'b1,
  output var logic  wp_n = 1'b1,
  output var logic  io0 = 1'b0,
  input  wire logic io1
);
  // protect pin, moved between frames only
  task automatic set_wp(input logic v);
    wp_n <= v;
  endtask
  // one frame msb first, clock idle per mode
  task automatic xfer(input logic [63:0] d, input int nbits, input logic m3, input int hold_at,
                      output logic [7:0] rx);
    begin
      rx = 8'h00;
      sclk <= m3;
      repeat (4) @(posedge clk);
      cs_n <= 1'b0;
      repeat (4) @(posedge clk);
      for (int i = 0; i < nbits; i++)
      begin
        sclk <= 1'b0; // new bit after the falling edge
        io0 <= d[63 - i];
        repeat (4) @(posedge clk);
        if (i == hold_at)
        begin
          hold_n <= 1'b0; // pause only with the clock low
          repeat (40) @(posedge clk);
          hold_n <= 1'b1; // resume still selected, clock low
          repeat (8) @(posedge clk);
        end
        rx = {rx[6:0], io1}; // taken just before the rising edge
        sclk <= 1'b1;
        repeat (4) @(posedge clk);
      end
      sclk <= m3;
      repeat (4) @(posedge clk);
      cs_n <= 1'b1;
      io0 <= ~io0; // released line never keeps its last value
      repeat (8) @(posedge clk);
    end
  endtask
endmodule // spi_host_model
`default_nettype wire

// ==== bench/flash_front_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module flash_front_tb;
  import flash_front_pkg::*;
  // clock, reset and bus master drive
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  // bus answers and last results
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic [31:0] s_axi_rdata, rd;
  // link; undriven lines toggle
  wire logic   cs_n, sclk, hold_n, wp_n, io0_h;
  logic        data_in_io0_o, data_in_io0_oe, data_out_io1_o, data_out_io1_oe;
  logic        junk = 1'b0;
  logic [7:0]  rx;
  wire logic   data_in_io0_i = data_in_io0_oe ? data_in_io0_o : io0_h;
  wire logic   data_out_io1_i = data_out_io1_oe ? data_out_io1_o : junk;
  int          failures = 0, num_checks = 0;

  flash_front DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cs_n, .sclk, .hold_n, .wp_n,
    .data_in_io0_i, .data_in_io0_o, .data_in_io0_oe, .data_out_io1_i, .data_out_io1_o, .data_out_io1_oe);
  spi_host_model host (.clk(aclk), .cs_n, .sclk, .hold_n, .wp_n, .io0(io0_h), .io1(data_out_io1_i));

  initial
  begin
    forever #50 aclk = ~aclk;
  end
  always @(posedge aclk) junk <= ~junk;

  task automatic chk(input string n, input logic [39:0] e, input logic [39:0] g);
    begin
      num_checks++;
      if (g !== e)
      begin
        failures++;
        $display("ERROR %s expected %h seen %h", n, e, g);
      end
    end
  endtask
  task automatic stop_test();
    begin
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  // one bus cycle; answer readies stand from the start
  task automatic axi(input logic we, input logic [11:0] a, input logic [31:0] d);
    begin
      s_axi_awaddr <= a;
      s_axi_araddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= we;
      s_axi_wvalid <= we;
      s_axi_arvalid <= !we;
      s_axi_bready <= we;
      s_axi_rready <= !we;
      forever
      begin
        @(posedge aclk);
        if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready))
          break;
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end
      rd = s_axi_rdata;
      rs = we ? s_axi_bresp : s_axi_rresp;
      s_axi_bready <= 1'b0;
      s_axi_rready <= 1'b0;
      @(posedge aclk);
    end
  endtask
  task automatic rdc(input logic [11:0] a, input logic [33:0] e);
    begin
      axi(1'b0, a, 32'h0);
      chk("bus read", {6'h0, e}, {6'h0, rs, rd});
    end
  endtask
  task automatic wrc(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
    begin
      axi(1'b1, a, d);
      chk("bus write", {38'h0, e}, {38'h0, rs});
    end
  endtask
  // commands go out in mode 3, status reads in mode 0
  task automatic cmd(input logic [63:0] d, input int n);
    host.xfer(d, n, 1'b1, -1, rx);
  endtask
  task automatic rdsr(input logic [7:0] e, input int h);
    begin
      host.xfer({8'h05, 56'h0}, 16, 1'b0, h, rx);
      chk("status", {32'h0, e}, {32'h0, rx});
    end
  endtask

  task automatic t_regs();
    begin
      rdc(12'h000, {2'h0, 32'h400});
      rdc(12'h004, {2'h0, 32'h5A});
      wrc(12'h004, 32'hA5, 2'h0);
      wrc(12'h000, 32'hFF, 2'h0);
      rdc(12'h004, {2'h0, 32'hA5});
      rdc(12'h000, {2'h0, 32'h400});
      wrc(12'h008, 32'h1, 2'h2);
      rdc(12'h008, {2'h2, 32'h0});
      $display("t_regs done");
    end
  endtask
  task automatic t_latch();
    begin
      rdsr(8'h00, -1);
      cmd({8'h06, 56'h0}, 9);
      rdsr(8'h00, -1);
      cmd({16'hFF06, 48'h0}, 16);
      rdsr(8'h00, -1);
      cmd({8'h06, 56'h0}, 8);
      rdsr(8'h02, -1);
      cmd({8'h04, 56'h0}, 8);
      rdsr(8'h00, -1);
      $display("t_latch done");
    end
  endtask
  task automatic t_prot();
    begin
      cmd({8'h06, 56'h0}, 8);
      cmd({16'h010C, 48'h0}, 16);
      rdsr(8'h0C, -1);
      host.set_wp(1'b0);
      cmd({8'h06, 56'h0}, 8);
      cmd({16'h0100, 48'h0}, 16);
      rdsr(8'h0C, -1);
      host.set_wp(1'b1);
      cmd({8'h06, 56'h0}, 8);
      cmd({32'h2000_0000, 32'h0}, 32);
      rdsr(8'h0E, -1);
      cmd({16'h0100, 48'h0}, 16);
      rdsr(8'h00, -1);
      $display("t_prot done");
    end
  endtask
  // erase with a paused read, then program
  task automatic t_erase();
    begin
      cmd({8'h06, 56'h0}, 8);
      cmd({32'h2000_1000, 32'h0}, 32);
      rdsr(8'h03, 12);
      repeat (100)
      begin
        host.xfer({8'h05, 56'h0}, 16, 1'b0, -1, rx);
        if (rx[0] === 1'b0)
          break;
      end
      chk("status", 40'h0, {32'h0, rx});
      cmd({8'h06, 56'h0}, 8);
      cmd({32'h0200_1000, 8'h3C, 24'h0}, 40);
      repeat (600) @(posedge aclk);
      cmd({32'h0300_1000, 32'h0}, 40);
      chk("array", 40'h3C, {32'h0, rx});
      $display("t_erase done");
    end
  endtask
  task automatic t_pd();
    begin
      cmd({8'hB9, 56'h0}, 8);
      cmd({8'h06, 56'h0}, 8);
      host.xfer({8'hAB, 56'h0}, 40, 1'b1, -1, rx);
      chk("signature", 40'hA5, {32'h0, rx});
      rdsr(8'h00, -1);
      $display("t_pd done");
    end
  endtask

  initial
  begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_latch();
    t_prot();
    t_erase();
    t_pd();
    stop_test();
  end
  // watchdog: the run needs well under 60000 cycles
  initial
  begin
    #6000000;
    failures++;
    stop_test();
  end
endmodule // flash_front_tb
`default_nettype wire
